// ===== lpddr_bank_legality.sv
// command decode and per-bank legality tracking for a low-power ddr device
`timescale 1ns/1ps
`default_nettype none
`include "lpddr_bank_regs.svh"
module lpddr_bank_legality
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// command pins, sampled at the clock
	input wire logic i_cke,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [`BANK_W-1:0] i_bank_addr,
	input wire logic i_auto_precharge_bit,
	// power-down exit marks from the power logic
	input wire logic i_power_down_exit,
	input wire logic i_self_refresh_exit,
	// bank states and status
	output logic [4*`NUM_BANKS-1:0] o_bank_state,
	output logic o_all_idle,
	output logic o_cmd_illegal,
	output logic o_deep_power_down,
	output logic [`BANK_W-1:0] o_last_read_bank
);
	logic cke_prev_q;
	logic [`CNT_W-1:0] exit_cnt_q;
	logic decode_en;
	logic [2:0] cmd;
	logic [`NUM_BANKS-1:0] act_v;
	logic [`NUM_BANKS-1:0] rd_v;
	logic [`NUM_BANKS-1:0] wr_v;
	logic [`NUM_BANKS-1:0] pre_v;
	logic [`NUM_BANKS-1:0] term_v;
	logic [`NUM_BANKS-1:0] pp_v;
	logic [`NUM_BANKS-1:0] idle_v;
	lpddr_bank_pkg::bank_state_t st [`NUM_BANKS];
	logic all_idle;
	logic illegal_d;
	logic last_read_valid_q;

	// is this state one of the uninterruptible per-bank ones
	function automatic logic bank_busy(input lpddr_bank_pkg::bank_state_t s);
		bank_busy = (s == lpddr_bank_pkg::BANK_ACTIVATING) ||
			(s == lpddr_bank_pkg::BANK_PRECHARGING) ||
			(s == lpddr_bank_pkg::BANK_READ_AP) ||
			(s == lpddr_bank_pkg::BANK_WRITE_AP);
	endfunction

	// does the state hold a global wait (refresh, mode access)
	function automatic logic global_wait(input lpddr_bank_pkg::bank_state_t s);
		global_wait = (s == lpddr_bank_pkg::BANK_REFRESHING) ||
			(s == lpddr_bank_pkg::BANK_MODE_ACCESS);
	endfunction

	// previous clock enable and exit-time counter
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cke_prev_q <= 1'b0;
			exit_cnt_q <= 8'h00;
		end
		else
		begin
			cke_prev_q <= i_cke;
			if (i_self_refresh_exit)
				exit_cnt_q <= 8'(`SELF_REFRESH_EXIT_CYC);
			else if (i_power_down_exit)
				exit_cnt_q <= 8'(`POWER_DOWN_EXIT_CYC);
			else if (exit_cnt_q != 8'h00)
				exit_cnt_q <= exit_cnt_q - 8'h01;
		end
	end

	// decode only with clock enable high at both edges and exit met
	assign decode_en = cke_prev_q && i_cke && (exit_cnt_q == 8'h00) && !i_cs_n;
	assign cmd = {i_ras_n, i_cas_n, i_we_n};

	// per-bank event vectors
	always_comb
	begin
		act_v = '0;
		rd_v = '0;
		wr_v = '0;
		pre_v = '0;
		term_v = '0;
		if (decode_en)
		begin
			case (cmd)
				`CMD_ACTIVE: act_v[i_bank_addr] = 1'b1;
				`CMD_READ: rd_v[i_bank_addr] = 1'b1;
				`CMD_WRITE: wr_v[i_bank_addr] = 1'b1;
				`CMD_PRECHARGE:
				begin
					if (i_auto_precharge_bit)
						pre_v = '1;
					else
						pre_v[i_bank_addr] = 1'b1;
				end
				`CMD_TERMINATE:
				begin
					if (last_read_valid_q)
						term_v[o_last_read_bank] = 1'b1;
				end
				default:
				begin
					act_v = '0;
				end
			endcase
		end
	end

	// one state machine per bank
	genvar b;
	generate
		for (b = 0; b < `NUM_BANKS; b++)
		begin : g_bank
			lpddr_bank_fsm u_fsm
			(
				.i_mclk(i_mclk),
				.i_nrst(i_nrst),
				.i_act(act_v[b] && !bank_busy(st[b])),
				.i_rd(rd_v[b] && !bank_busy(st[b])),
				.i_wr(wr_v[b] && !bank_busy(st[b])),
				.i_ap(i_auto_precharge_bit),
				.i_pre(pre_v[b] && !bank_busy(st[b])),
				.i_term(term_v[b]),
				.i_refresh(decode_en && cmd == `CMD_REFRESH && all_idle),
				.i_mode_load(decode_en && cmd == `CMD_MODE_LOAD && all_idle),
				.o_state(st[b]),
				.o_precharge_period(pp_v[b])
			);
			assign idle_v[b] = (st[b] == lpddr_bank_pkg::BANK_IDLE);
		end
	endgenerate

	assign all_idle = &idle_v;

	// flag a command the current bank states do not allow
	always_comb
	begin
		illegal_d = 1'b0;
		if (decode_en)
		begin
			case (cmd)
				`CMD_NOP: illegal_d = 1'b0;
				`CMD_REFRESH, `CMD_MODE_LOAD: illegal_d = !all_idle;
				`CMD_TERMINATE: illegal_d = !last_read_valid_q;
				`CMD_PRECHARGE: illegal_d = i_auto_precharge_bit ?
					(|(act_v | pre_v) && 1'b0) || global_wait(st[0])
					: bank_busy(st[i_bank_addr]) || global_wait(st[i_bank_addr]);
				default: illegal_d = bank_busy(st[i_bank_addr]) ||
					global_wait(st[i_bank_addr]);
			endcase
		end
	end

	// most recent read burst for burst terminate
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_last_read_bank <= 2'h0;
			last_read_valid_q <= 1'b0;
		end
		else if (|rd_v && !i_auto_precharge_bit)
		begin
			o_last_read_bank <= i_bank_addr;
			last_read_valid_q <= 1'b1;
		end
		else if (|term_v || (|wr_v))
			last_read_valid_q <= 1'b0;
	end

	// status outputs, all registered
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_bank_state <= '0;
			o_all_idle <= 1'b1;
			o_cmd_illegal <= 1'b0;
			o_deep_power_down <= 1'b0;
		end
		else
		begin
			o_bank_state <= {st[3], st[2], st[1], st[0]};
			o_all_idle <= all_idle;
			o_cmd_illegal <= illegal_d;
			// terminate code with clock enable falling enters deep power-down
			o_deep_power_down <= cke_prev_q && !i_cke && !i_cs_n &&
				cmd == `CMD_TERMINATE && all_idle;
		end
	end

	// deselect never moves an idle bank
	a_deselect_holds: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(i_cs_n && st[0] == lpddr_bank_pkg::BANK_IDLE) |=>
		st[0] == lpddr_bank_pkg::BANK_IDLE)
		else $error("deselect changed an idle bank");

	// active to idle bank 0 opens it
	a_active_opens: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(decode_en && cmd == `CMD_ACTIVE && i_bank_addr == 2'h0 &&
		st[0] == lpddr_bank_pkg::BANK_IDLE) |=> st[0] == lpddr_bank_pkg::BANK_ACTIVATING)
		else $error("active did not open the row");

	// without both clock enable edges nothing is decoded
	a_cke_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!(cke_prev_q && i_cke) |-> (act_v == '0 && pre_v == '0 && rd_v == '0))
		else $error("decode without clock enable");

	// precharge all sends every row-active bank to precharging
	a_precharge_all: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(decode_en && cmd == `CMD_PRECHARGE && i_auto_precharge_bit &&
		st[1] == lpddr_bank_pkg::BANK_ACTIVE) |=> st[1] == lpddr_bank_pkg::BANK_PRECHARGING)
		else $error("precharge all missed a bank");

	// a bank command into a busy bank raises the illegal flag
	a_busy_refused: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(decode_en && (cmd == `CMD_ACTIVE || cmd == `CMD_READ) && i_bank_addr == 2'h0 &&
		bank_busy(st[0])) |=> o_cmd_illegal)
		else $error("busy bank took a command");

	// terminate ends the read burst of the recorded bank
	a_terminate_cuts: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(decode_en && cmd == `CMD_TERMINATE && last_read_valid_q &&
		o_last_read_bank == 2'h2 && st[2] == lpddr_bank_pkg::BANK_READ) |=>
		st[2] == lpddr_bank_pkg::BANK_ACTIVE)
		else $error("terminate missed the read burst");

	// refresh on all idle banks puts every bank into refreshing
	a_refresh_all: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(decode_en && cmd == `CMD_REFRESH && all_idle) |=>
		st[3] == lpddr_bank_pkg::BANK_REFRESHING)
		else $error("refresh missed a bank");
endmodule
`default_nettype wire

// ===== lpddr_bank_regs.svh
// timing counts and field positions for the bank command legality block
`ifndef LPDDR_BANK_REGS_SVH
`define LPDDR_BANK_REGS_SVH

// clock period in ns
`define CLK_PERIOD_NS 25
// timing figures in ns
`define ROW_PRECHARGE_TIME_NS 30
`define ACTIVATE_TO_COLUMN_DELAY_NS 30
`define REFRESH_CYCLE_TIME_NS 110
`define WRITE_RECOVERY_TIME_NS 15
`define POWER_DOWN_EXIT_TIME_NS 25
`define SELF_REFRESH_EXIT_TIME_NS 200
// mode register delay is given in clocks
`define MODE_REGISTER_DELAY_CYC 2
// least times round up to whole cycles
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_PRECHARGE_CYC `CEIL_CYC(`ROW_PRECHARGE_TIME_NS)
`define ACTIVATE_TO_COLUMN_CYC `CEIL_CYC(`ACTIVATE_TO_COLUMN_DELAY_NS)
`define REFRESH_CYCLE_CYC `CEIL_CYC(`REFRESH_CYCLE_TIME_NS)
`define WRITE_RECOVERY_CYC `CEIL_CYC(`WRITE_RECOVERY_TIME_NS)
`define POWER_DOWN_EXIT_CYC `CEIL_CYC(`POWER_DOWN_EXIT_TIME_NS)
`define SELF_REFRESH_EXIT_CYC `CEIL_CYC(`SELF_REFRESH_EXIT_TIME_NS)
// bank count and widths
`define NUM_BANKS 4
`define BANK_W 2
`define CNT_W 8
// burst length in clocks (pairs of data)
`define BURST_CLKS 4
// command code bits {ras_n,cas_n,we_n}
`define CMD_ACTIVE 3'h3
`define CMD_READ 3'h5
`define CMD_WRITE 3'h4
`define CMD_TERMINATE 3'h6
`define CMD_PRECHARGE 3'h2
`define CMD_REFRESH 3'h1
`define CMD_MODE_LOAD 3'h0
`define CMD_NOP 3'h7

`endif

// ===== lpddr_bank_pkg.sv
// types for the bank command legality block
package lpddr_bank_pkg;
	// per-bank state, gray along idle->activating->active->read
	typedef enum logic [3:0] {
		BANK_IDLE = 4'h0,
		BANK_ACTIVATING = 4'h1,
		BANK_ACTIVE = 4'h3,
		BANK_READ = 4'h2,
		BANK_WRITE = 4'h6,
		BANK_READ_AP = 4'h7,
		BANK_WRITE_AP = 4'h5,
		BANK_PRECHARGING = 4'h4,
		BANK_REFRESHING = 4'hC,
		BANK_MODE_ACCESS = 4'hD
	} bank_state_t;
endpackage

// ===== lpddr_bank_fsm.sv
// one bank's state machine with its interval counter
`timescale 1ns/1ps
`default_nettype none
`include "lpddr_bank_regs.svh"
module lpddr_bank_fsm
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// decoded events for this bank
	input wire logic i_act,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic i_ap,
	input wire logic i_pre,
	input wire logic i_term,
	input wire logic i_refresh,
	input wire logic i_mode_load,
	// state
	output var lpddr_bank_pkg::bank_state_t o_state,
	output logic o_precharge_period
);
	logic [`CNT_W-1:0] cnt_q;
	logic [`CNT_W-1:0] cnt_d;
	lpddr_bank_pkg::bank_state_t state_d;
	logic pp_d;
	logic wait_done;

	assign wait_done = (cnt_q == 8'h00);

	// next state and counter load
	always_comb
	begin
		state_d = o_state;
		cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
		pp_d = o_precharge_period;
		case (o_state)
			lpddr_bank_pkg::BANK_IDLE:
			begin
				if (i_act)
				begin
					state_d = lpddr_bank_pkg::BANK_ACTIVATING;
					cnt_d = 8'(`ACTIVATE_TO_COLUMN_CYC - 1);
				end
				else if (i_refresh)
				begin
					state_d = lpddr_bank_pkg::BANK_REFRESHING;
					cnt_d = 8'(`REFRESH_CYCLE_CYC - 1);
				end
				else if (i_mode_load)
				begin
					state_d = lpddr_bank_pkg::BANK_MODE_ACCESS;
					cnt_d = 8'(`MODE_REGISTER_DELAY_CYC - 1);
				end
				else if (i_pre)
				begin
					state_d = lpddr_bank_pkg::BANK_PRECHARGING;
					cnt_d = 8'(`ROW_PRECHARGE_CYC - 1);
				end
			end
			lpddr_bank_pkg::BANK_ACTIVE, lpddr_bank_pkg::BANK_READ,
			lpddr_bank_pkg::BANK_WRITE:
			begin
				if (o_state != lpddr_bank_pkg::BANK_ACTIVE && wait_done)
					state_d = lpddr_bank_pkg::BANK_ACTIVE; // burst ran out
				if (i_term && o_state == lpddr_bank_pkg::BANK_READ)
					state_d = lpddr_bank_pkg::BANK_ACTIVE;
				if (i_pre)
				begin
					state_d = lpddr_bank_pkg::BANK_PRECHARGING;
					cnt_d = 8'(`ROW_PRECHARGE_CYC - 1);
				end
				else if (i_rd || i_wr)
				begin
					pp_d = 1'b0;
					if (i_ap)
					begin
						state_d = i_rd ? lpddr_bank_pkg::BANK_READ_AP
							: lpddr_bank_pkg::BANK_WRITE_AP;
						cnt_d = i_rd ? 8'(`BURST_CLKS - 1)
							: 8'(`BURST_CLKS + `WRITE_RECOVERY_CYC - 1);
					end
					else
					begin
						state_d = i_rd ? lpddr_bank_pkg::BANK_READ
							: lpddr_bank_pkg::BANK_WRITE;
						cnt_d = 8'(`BURST_CLKS - 1);
					end
				end
			end
			lpddr_bank_pkg::BANK_READ_AP, lpddr_bank_pkg::BANK_WRITE_AP:
			begin
				if (wait_done && !o_precharge_period)
				begin
					pp_d = 1'b1;
					cnt_d = 8'(`ROW_PRECHARGE_CYC - 1);
				end
				else if (wait_done)
				begin
					pp_d = 1'b0;
					state_d = lpddr_bank_pkg::BANK_IDLE;
				end
			end
			lpddr_bank_pkg::BANK_ACTIVATING:
				if (wait_done)
					state_d = lpddr_bank_pkg::BANK_ACTIVE;
			lpddr_bank_pkg::BANK_PRECHARGING, lpddr_bank_pkg::BANK_REFRESHING,
			lpddr_bank_pkg::BANK_MODE_ACCESS:
				if (wait_done)
					state_d = lpddr_bank_pkg::BANK_IDLE;
			default:
				state_d = lpddr_bank_pkg::BANK_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_state <= lpddr_bank_pkg::BANK_IDLE;
		else
			o_state <= state_d;
	end

	// interval counter, one per bank
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt_q <= 8'h00;
			o_precharge_period <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			o_precharge_period <= pp_d;
		end
	end

	// precharging ends exactly after the row precharge count
	a_precharge_length: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(o_state != lpddr_bank_pkg::BANK_PRECHARGING ##1
		o_state == lpddr_bank_pkg::BANK_PRECHARGING) |->
		##(`ROW_PRECHARGE_CYC) o_state == lpddr_bank_pkg::BANK_IDLE)
		else $error("precharge period wrong length");

	// activating lasts the column delay, then row active
	a_activate_length: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(o_state == lpddr_bank_pkg::BANK_IDLE && i_act) |->
		##1 o_state == lpddr_bank_pkg::BANK_ACTIVATING ##(`ACTIVATE_TO_COLUMN_CYC)
		o_state == lpddr_bank_pkg::BANK_ACTIVE)
		else $error("activate period wrong length");

	// refresh holds the bank for the refresh cycle time
	a_refresh_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(o_state == lpddr_bank_pkg::BANK_IDLE && i_refresh && !i_act) |->
		##1 o_state == lpddr_bank_pkg::BANK_REFRESHING
		##(`REFRESH_CYCLE_CYC) o_state == lpddr_bank_pkg::BANK_IDLE)
		else $error("refresh period wrong length");

	// mode access returns to idle after the mode register delay
	a_mode_delay: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(o_state == lpddr_bank_pkg::BANK_IDLE && i_mode_load && !i_act && !i_refresh) |->
		##1 o_state == lpddr_bank_pkg::BANK_MODE_ACCESS
		##(`MODE_REGISTER_DELAY_CYC) o_state == lpddr_bank_pkg::BANK_IDLE)
		else $error("mode access wrong length");
endmodule
`default_nettype wire

// ===== lpddr_ctrl_model.sv
// controller model that drives the command pins of the bank block
`timescale 1ns/1ps
`default_nettype none
`include "lpddr_bank_regs.svh"
module lpddr_ctrl_model
(
	// clock
	input wire logic i_mclk,
	// command pins
	output logic o_cke,
	output logic o_cs_n,
	output logic [2:0] o_cmd,
	output logic [1:0] o_bank_addr,
	output logic o_ap
);
	// bus starts deselected with clock enable high
	initial
	begin
		o_cke = 1'b1;
		o_cs_n = 1'b1;
		o_cmd = `CMD_NOP;
		o_bank_addr = 2'h0;
		o_ap = 1'b0;
	end
	// one command held up to the edge that takes it; callers other than the refuse test wait out busy banks,
	// send refresh and mode load only when all idle outside the refuse test, never write over a live read,
	// keep auto-precharge banks on nop, and aim terminate at any bank address, not only the reading bank
	task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic ap,
		input logic k);
	begin
		o_cke = k;
		o_cs_n = 1'b0;
		o_cmd = c;
		o_bank_addr = b;
		o_ap = ap;
		@(posedge i_mclk);
		#2;
	end
	endtask
	// deselect for n edges; no data lines here, so nothing is left to mask
	task automatic idle(input int n, input logic [2:0] c);
	begin
		o_cke = 1'b1;
		o_cs_n = 1'b1;
		o_cmd = c;
		o_bank_addr = ~o_bank_addr;
		o_ap = ~o_ap;
		repeat (n) @(posedge i_mclk);
		#2;
	end
	endtask
endmodule
`default_nettype wire

// ===== tb_lpddr_bank_legality.sv
// self-checking bench for the bank command legality block
`timescale 1ns/1ps
`default_nettype none
`include "lpddr_bank_regs.svh"
module tb_lpddr_bank_legality;
	logic mclk, nrst, cke, cs_n, ap, sr_exit, pd_exit, all_idle, illegal, deep_pd;
	logic [2:0] cmd;
	logic [1:0] ba, last_rd;
	logic [15:0] bank_state;
	int n_errors, checks, cycles, n_ill, n_deep;

	// controller on the command pins
	lpddr_ctrl_model u_lpddr_ctrl_model (.i_mclk(mclk), .o_cke(cke), .o_cs_n(cs_n),
		.o_cmd(cmd), .o_bank_addr(ba), .o_ap(ap));
	// block under test
	lpddr_bank_legality u_lpddr_bank_legality (.i_mclk(mclk), .i_nrst(nrst), .i_cke(cke),
		.i_cs_n(cs_n), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
		.i_bank_addr(ba), .i_auto_precharge_bit(ap), .i_power_down_exit(pd_exit),
		.i_self_refresh_exit(sr_exit), .o_bank_state(bank_state), .o_all_idle(all_idle),
		.o_cmd_illegal(illegal), .o_deep_power_down(deep_pd), .o_last_read_bank(last_rd));

	// free-running clock
	always #12.5 mclk = ~mclk;

	// pulse counters and the run limit
	always @(posedge mclk)
	begin
		cycles++;
		if (illegal === 1'b1)
			n_ill++;
		if (deep_pd === 1'b1)
			n_deep++;
		if (cycles == 4000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	// counts, verdict and end of run
	task automatic give_verdict();
	begin
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	// compare one value and count it
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
	begin
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	end
	endtask

	// wait up to lim edges for a bank to show a state, then compare
	task automatic wait_st(input int b, input logic [3:0] s, input int lim);
	begin
		for (int i = 0; i < lim && bank_state[4*b+:4] !== s; i++)
		begin
			@(posedge mclk);
			#2;
		end
		chk("bank state", s, bank_state[4*b+:4]);
	end
	endtask

	// short hands for the controller
	task automatic raw(input logic [2:0] c, input logic [1:0] b, input logic a);
	begin
		u_lpddr_ctrl_model.issue(c, b, a, 1'b1);
	end
	endtask
	task automatic idl(input int n);
	begin
		u_lpddr_ctrl_model.idle(n, `CMD_NOP);
	end
	endtask
	task automatic iss(input logic [2:0] c, input logic [1:0] b, input logic a);
	begin
		raw(c, b, a);
		idl(1);
	end
	endtask

	// open, read, cut the read with a precharge, close
	task automatic row_test();
	int i0;
	begin
		i0 = n_ill;
		iss(`CMD_ACTIVE, 0, 0);
		wait_st(0, 4'h1, 4);
		wait_st(0, 4'h3, 4);
		iss(`CMD_READ, 0, 0);
		wait_st(0, 4'h2, 4);
		chk("last read bank", 4'h0, {2'h0, last_rd});
		iss(`CMD_PRECHARGE, 0, 0);
		wait_st(0, 4'h4, 3);
		wait_st(0, 4'h0, 4);
		chk("illegal count", 4'h0, 4'(n_ill - i0));
		$display("row test done");
	end
	endtask

	// two banks side by side, write restart and cut, terminate from any bank
	task automatic banks_test();
	begin
		raw(`CMD_ACTIVE, 1, 0);
		iss(`CMD_ACTIVE, 2, 0);
		wait_st(1, 4'h3, 5);
		wait_st(2, 4'h3, 5);
		raw(`CMD_WRITE, 1, 0);
		iss(`CMD_WRITE, 1, 0);
		wait_st(1, 4'h6, 4);
		iss(`CMD_PRECHARGE, 1, 0);
		wait_st(1, 4'h4, 3);
		iss(`CMD_READ, 2, 0);
		wait_st(2, 4'h2, 4);
		iss(`CMD_TERMINATE, 3, 0);
		wait_st(2, 4'h3, 1);
		chk("last read bank", 4'h2, {2'h0, last_rd});
		wait_st(1, 4'h0, 4);
		iss(`CMD_PRECHARGE, 2, 0);
		wait_st(2, 4'h0, 6);
		$display("banks test done");
	end
	endtask

	// read and write with auto precharge close the bank on their own
	task automatic ap_test();
	begin
		iss(`CMD_ACTIVE, 3, 0);
		wait_st(3, 4'h3, 5);
		iss(`CMD_READ, 3, 1);
		wait_st(3, 4'h7, 4);
		wait_st(3, 4'h0, 12);
		iss(`CMD_ACTIVE, 3, 0);
		wait_st(3, 4'h3, 5);
		iss(`CMD_WRITE, 3, 1);
		wait_st(3, 4'h5, 4);
		wait_st(3, 4'h0, 12);
		$display("auto precharge test done");
	end
	endtask

	// commands into busy states are refused and flagged
	task automatic refuse_test();
	int i0;
	begin
		i0 = n_ill;
		raw(`CMD_ACTIVE, 0, 0);
		iss(`CMD_ACTIVE, 0, 0);
		wait_st(0, 4'h3, 5);
		chk("illegal count", 4'h1, 4'(n_ill - i0));
		iss(`CMD_REFRESH, 0, 0);
		idl(2);
		wait_st(0, 4'h3, 0);
		chk("illegal count", 4'h2, 4'(n_ill - i0));
		raw(`CMD_PRECHARGE, 0, 0);
		iss(`CMD_READ, 0, 0);
		wait_st(0, 4'h0, 5);
		chk("illegal count", 4'h3, 4'(n_ill - i0));
		$display("refuse test done");
	end
	endtask

	// precharge all, refresh and mode load over all banks
	task automatic all_test();
	begin
		raw(`CMD_ACTIVE, 0, 0);
		iss(`CMD_ACTIVE, 1, 0);
		wait_st(1, 4'h3, 5);
		iss(`CMD_PRECHARGE, 2, 1);
		wait_st(0, 4'h4, 3);
		wait_st(1, 4'h4, 0);
		wait_st(1, 4'h0, 4);
		idl(1);
		chk("all idle", 4'h1, {3'h0, all_idle});
		iss(`CMD_REFRESH, 0, 0);
		wait_st(2, 4'hC, 4);
		chk("all idle", 4'h0, {3'h0, all_idle});
		wait_st(2, 4'h0, 8);
		iss(`CMD_MODE_LOAD, 1, 0);
		wait_st(3, 4'hD, 4);
		wait_st(3, 4'h0, 5);
		$display("all banks test done");
	end
	endtask

	// deselect, nop and clock-enable history start nothing
	task automatic quiet_test();
	begin
		iss(`CMD_ACTIVE, 0, 0);
		wait_st(0, 4'h3, 5);
		u_lpddr_ctrl_model.idle(3, `CMD_READ);
		wait_st(0, 4'h3, 0);
		raw(`CMD_NOP, 0, 0);
		iss(`CMD_NOP, 0, 0);
		wait_st(0, 4'h3, 0);
		u_lpddr_ctrl_model.issue(`CMD_READ, 0, 0, 1'b0);
		iss(`CMD_READ, 0, 0);
		idl(2);
		wait_st(0, 4'h3, 0);
		sr_exit = 1'b1;
		@(posedge mclk);
		#2;
		sr_exit = 1'b0;
		idl(2);
		iss(`CMD_READ, 0, 0);
		idl(2);
		wait_st(0, 4'h3, 0);
		idl(8);
		pd_exit = 1'b1;
		@(posedge mclk);
		#2;
		pd_exit = 1'b0;
		iss(`CMD_READ, 0, 0);
		idl(1);
		wait_st(0, 4'h3, 0);
		iss(`CMD_READ, 0, 0);
		wait_st(0, 4'h2, 4);
		iss(`CMD_PRECHARGE, 0, 0);
		wait_st(0, 4'h0, 6);
		$display("quiet test done");
	end
	endtask

	// deep power-down code, then a reset in mid-run
	task automatic end_test();
	int d0;
	int i0;
	begin
		d0 = n_deep;
		u_lpddr_ctrl_model.issue(`CMD_TERMINATE, 0, 0, 1'b0);
		idl(3);
		chk("deep entry count", 4'h1, 4'(n_deep - d0));
		nrst = 1'b0;
		@(posedge mclk);
		#2;
		nrst = 1'b1;
		idl(2);
		for (int b = 0; b < 4; b++)
			wait_st(b, 4'h0, 0);
		chk("all idle", 4'h1, {3'h0, all_idle});
		i0 = n_ill;
		iss(`CMD_TERMINATE, 0, 0);
		idl(2);
		chk("deep entry count", 4'h1, 4'(n_deep - d0));
		chk("illegal count", 4'h1, 4'(n_ill - i0));
		$display("end test done");
	end
	endtask

	// reset, then the scenarios in turn
	initial
	begin
		mclk = 1'b0;
		nrst = 1'b0;
		sr_exit = 1'b0;
		n_errors = 0;
		checks = 0;
		cycles = 0;
		n_ill = 0;
		n_deep = 0;
		pd_exit = 1'b0;
		repeat (10) @(posedge mclk);
		#2;
		nrst = 1'b1;
		idl(2);
		chk("all idle", 4'h1, {3'h0, all_idle});
		row_test();
		banks_test();
		ap_test();
		refuse_test();
		all_test();
		quiet_test();
		end_test();
		give_verdict();
	end
endmodule
`default_nettype wire
